//--- rtl/sbgt_pkg.sv
// package: register map, control fields and constants of the gated timer
package sbgt_pkg;
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned SYNC_STAGES = 3;
	localparam logic [4:0] OFS_CONTROL = 5'h00;
	localparam logic [4:0] OFS_PERIOD = 5'h04;
	localparam logic [4:0] OFS_COUNT = 5'h08;
	localparam logic [4:0] OFS_STATUS = 5'h0C;
	localparam logic [4:0] OFS_MASK = 5'h10;
	localparam logic [4:0] OFS_POWER = 5'h14;
	localparam int unsigned BIT_RUN = 15;
	localparam int unsigned BIT_IDLE_HALT = 13;
	localparam int unsigned BIT_GATE = 6;
	localparam int unsigned BIT_PS_HI = 5;
	localparam int unsigned BIT_PS_LO = 4;
	localparam int unsigned BIT_SYNC = 2;
	localparam int unsigned BIT_SRC = 1;
	localparam logic [15:0] CONTROL_MASK = 16'hA076;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [1:0] EV_MATCH = 2'h1;
	localparam logic [1:0] EV_GATE_FALL = 2'h2;
	localparam int unsigned EV_W = 2;
	localparam int unsigned BIT_IDLE = 0;
	localparam int unsigned BIT_SLEEP = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] PS_DIV1 = 2'h0;
	localparam logic [1:0] PS_DIV8 = 2'h1;
	localparam logic [1:0] PS_DIV64 = 2'h2;
	localparam logic [1:0] PS_DIV256 = 2'h3;
	localparam logic [7:0] PS_LAST1 = 8'h00;
	localparam logic [7:0] PS_LAST8 = 8'h07;
	localparam logic [7:0] PS_LAST64 = 8'h3F;
	localparam logic [7:0] PS_LAST256 = 8'hFF;
	typedef enum logic [2:0] {
		SBGT_WIDLE = 3'b001,
		SBGT_WHALF = 3'b010,
		SBGT_WRESP = 3'b100
	} sbgt_wstate_t;
endpackage : sbgt_pkg

//--- rtl/sbgt_sync.sv
// three-stage synchroniser with second/third agreement for a pin input
module sbgt_sync
	import sbgt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic pin,
	output logic level
);
	logic [SYNC_STAGES-1:0] stage;
	logic [SYNC_STAGES-1:0] next_stage;
	logic next_level;

	// first stage feeds only the second; level moves when stages 2 and 3 agree
	always_comb begin
		next_stage = {stage[SYNC_STAGES-2:0], pin};
		next_level = level;
		if (stage[1] == stage[2]) begin
			next_level = stage[2];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage <= '0;
			level <= 1'b0;
		end else if (ce) begin
			stage <= next_stage;
			level <= next_level;
		end
	end
endmodule // sbgt_sync

//--- rtl/sbgt_timer.sv
// 16-bit gated timer/counter with AXI4-Lite registers and interrupt
module sbgt_timer
	import sbgt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic external_count_pin,
	input wire logic gate_pin,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq
);
	logic ext_level, gate_level, ext_raw_q, ext_sync_q, gate_q;
	logic [15:0] timer_control, period_value, count;
	logic [EV_W-1:0] status, mask;
	logic [1:0] power;
	logic [7:0] prescale_cnt;
	sbgt_wstate_t wstate, next_wstate;
	logic aw_have, w_have;
	logic [4:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data, next_rdata;
	logic [3:0] w_strb, next_w_strb;
	logic [15:0] next_control, next_period, next_count;
	logic [EV_W-1:0] next_status, next_mask;
	logic [1:0] next_power, next_bresp, next_rresp;
	logic [7:0] next_prescale;
	logic next_irq, next_ext_raw, next_ext_sync, next_gate;
	logic next_aw_have, next_w_have, next_bvalid;
	logic next_awready, next_wready, next_arready, next_rvalid;
	logic run_enable, idle_halt, gated_accumulate_enable;
	logic [1:0] prescale_select;
	logic external_clock_sync, clock_source_select;
	logic raw_edge, sync_edge, tick_src, halted, ps_tick;
	logic gate_fall, do_write, match;

	function automatic logic [7:0] ps_last(input logic [1:0] sel);
		case (sel)
			PS_DIV8: ps_last = PS_LAST8;
			PS_DIV64: ps_last = PS_LAST64;
			PS_DIV256: ps_last = PS_LAST256;
			default: ps_last = PS_LAST1;
		endcase
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old,
			input logic [31:0] data, input logic [3:0] strb);
		merge16 = old;
		if (strb[0]) begin
			merge16[7:0] = data[7:0];
		end
		if (strb[1]) begin
			merge16[15:8] = data[15:8];
		end
	endfunction

	sbgt_sync u_ext_sync (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.pin(external_count_pin), .level(ext_level));

	sbgt_sync u_gate_sync (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.pin(gate_pin), .level(gate_level));

	assign run_enable = timer_control[BIT_RUN];
	assign idle_halt = timer_control[BIT_IDLE_HALT];
	assign gated_accumulate_enable = timer_control[BIT_GATE];
	assign prescale_select = timer_control[BIT_PS_HI:BIT_PS_LO];
	assign external_clock_sync = timer_control[BIT_SYNC];
	assign clock_source_select = timer_control[BIT_SRC];

	// both modes see the pin through the synchroniser, one clock domain only;
	// the unsynchronised choice detects the rising edge one stage later
	assign raw_edge = ext_sync_q & ~ext_raw_q;
	assign sync_edge = ext_level & ~ext_sync_q;

	always_comb begin
		next_ext_raw = ext_sync_q;
		next_ext_sync = ext_level;
		next_gate = gate_level;
		halted = !run_enable || (idle_halt && power[BIT_IDLE]);
		gate_fall = gate_q & ~gate_level;
		if (clock_source_select) begin
			tick_src = external_clock_sync ? sync_edge : raw_edge;
		end else if (gated_accumulate_enable) begin
			tick_src = gate_level;
		end else begin
			tick_src = 1'b1;
		end
		ps_tick = 1'b0;
		next_prescale = prescale_cnt;
		if (halted) begin
			next_prescale = prescale_cnt;
		end else if (tick_src) begin
			if (prescale_cnt >= ps_last(prescale_select)) begin
				next_prescale = '0;
				ps_tick = 1'b1;
			end else begin
				next_prescale = prescale_cnt + 8'h01;
			end
		end
		match = (count == period_value);
		next_count = count;
		if (ps_tick) begin
			next_count = match ? COUNT_RESET : count + 16'h0001;
		end
		if (do_write && aw_addr[4:2] == OFS_COUNT[4:2]) begin
			next_count = merge16(count, w_data, w_strb);
		end
	end

	// write channel: address and data taken in either order
	always_comb begin
		next_wstate = wstate;
		next_aw_have = aw_have;
		next_w_have = w_have;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		do_write = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_have = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_have = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		case (wstate)
			SBGT_WIDLE, SBGT_WHALF: begin
				next_wstate = (next_aw_have || next_w_have) ?
					SBGT_WHALF : SBGT_WIDLE;
				if (aw_have && w_have) begin
					do_write = 1'b1;
					next_aw_have = 1'b0;
					next_w_have = 1'b0;
					next_bvalid = 1'b1;
					next_bresp = (aw_addr > OFS_POWER) ? RESP_SLVERR : RESP_OKAY;
					next_wstate = SBGT_WRESP;
				end
			end
			SBGT_WRESP: begin
				if (s_axi_bready) begin
					next_bvalid = 1'b0;
					next_wstate = SBGT_WIDLE;
				end
			end
			default: next_wstate = SBGT_WIDLE;
		endcase
		next_awready = !next_aw_have && (next_wstate != SBGT_WRESP);
		next_wready = !next_w_have && (next_wstate != SBGT_WRESP);
	end

	// register file, sticky events and read channel
	always_comb begin
		next_control = timer_control;
		next_period = period_value;
		next_mask = mask;
		next_power = power;
		if (do_write && aw_addr[4:2] == OFS_CONTROL[4:2]) begin
			next_control = merge16(timer_control, w_data, w_strb)
				& CONTROL_MASK;
		end
		if (do_write && aw_addr[4:2] == OFS_PERIOD[4:2]) begin
			next_period = merge16(period_value, w_data, w_strb);
		end
		if (do_write && aw_addr[4:2] == OFS_MASK[4:2] && w_strb[0]) begin
			next_mask = w_data[EV_W-1:0];
		end
		if (do_write && aw_addr[4:2] == OFS_POWER[4:2] && w_strb[0]) begin
			next_power = w_data[1:0];
		end
		next_status = status;
		if (do_write && aw_addr[4:2] == OFS_STATUS[4:2] && w_strb[0]) begin
			next_status = status & ~w_data[EV_W-1:0];
		end
		// set wins over a simultaneous write-one clear
		if (ps_tick && match) begin
			next_status = next_status | EV_MATCH;
		end
		if (!halted && gate_fall && gated_accumulate_enable
				&& !clock_source_select) begin
			next_status = next_status | EV_GATE_FALL;
		end
		next_irq = |(next_status & next_mask);
		next_arready = s_axi_arready || !s_axi_rvalid;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rresp = RESP_OKAY;
			next_rdata = '0;
			case (s_axi_araddr[4:2])
				OFS_CONTROL[4:2]: next_rdata[15:0] = timer_control;
				OFS_PERIOD[4:2]: next_rdata[15:0] = period_value;
				OFS_COUNT[4:2]: next_rdata[15:0] = count;
				OFS_STATUS[4:2]: next_rdata[EV_W-1:0] = status;
				OFS_MASK[4:2]: next_rdata[EV_W-1:0] = mask;
				OFS_POWER[4:2]: next_rdata[1:0] = power;
				default: next_rresp = RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_control <= CONTROL_RESET;
			period_value <= PERIOD_RESET;
			count <= COUNT_RESET;
			status <= '0;
			mask <= '0;
			power <= '0;
			prescale_cnt <= '0;
			irq <= 1'b0;
			ext_raw_q <= 1'b0;
			ext_sync_q <= 1'b0;
			gate_q <= 1'b0;
			wstate <= SBGT_WIDLE;
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (ce) begin
			timer_control <= next_control;
			period_value <= next_period;
			count <= next_count;
			status <= next_status;
			mask <= next_mask;
			power <= next_power;
			prescale_cnt <= next_prescale;
			irq <= next_irq;
			ext_raw_q <= next_ext_raw;
			ext_sync_q <= next_ext_sync;
			gate_q <= next_gate;
			wstate <= next_wstate;
			aw_have <= next_aw_have;
			w_have <= next_w_have;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	sequence tick_at_match_s;
		ps_tick && match;
	endsequence

	count_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce and tick_at_match_s) |=> count == COUNT_RESET)
		else $error("count did not clear after period match");
	match_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce and tick_at_match_s) |=> status[0])
		else $error("match flag not set");
	stop_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !run_enable && !do_write |=> $stable(count))
		else $error("count moved while stopped");
	idle_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && idle_halt && power[BIT_IDLE] && !do_write |=> $stable(count))
		else $error("count moved in idle with halt set");
	idle_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && run_enable && !idle_halt && !clock_source_select
		&& !gated_accumulate_enable && prescale_select == PS_DIV1
		&& !match && !do_write |=> count == $past(count) + 16'h0001)
		else $error("count did not advance");
	gate_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && gated_accumulate_enable && !clock_source_select && !gate_level
		&& !do_write |=> $stable(count))
		else $error("count moved with gate low");
	reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(timer_control & ~CONTROL_MASK) == 16'h0000)
		else $error("reserved control bit set");
	prescale_lim_a: assert property (@(posedge aclk) disable iff (!aresetn)
		prescale_cnt <= PS_LAST256)
		else $error("prescaler out of range");
	irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
		irq == |(status & mask))
		else $error("irq does not follow status and mask");
	ext_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && clock_source_select && !raw_edge && !sync_edge
		|-> !tick_src)
		else $error("external tick without edge");
endmodule // sbgt_timer

//--- tb/test_sbgt_timer.sv
// self-checking bench for the gated timer: registers, counting, interrupt
module test_sbgt_timer
	import sbgt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, ce, external_count_pin, gate_pin;
	logic [4:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, v;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, irq;
	int miscompares, n_tests, cyc, t_b, e, n;
	integer seed = 32'h4899B7CD;

	sbgt_timer u_sbgt_timer (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.external_count_pin(external_count_pin), .gate_pin(gate_pin),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .irq(irq));

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) cyc <= cyc + 1;

	// implemented control bits 15, 13, 6, 5-4, 2, 1; the rest read zero
	function automatic logic [31:0] ctl_exp(input logic [31:0] w);
		return {16'h0000, w[15:0] & 16'hA076};
	endfunction
	function automatic int div_of(input int p);
		case (p)
			0: return 1;
			1: return 8;
			2: return 64;
			default: return 256;
		endcase
	endfunction

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// a span check: prescaler phase and pin sync leave one tick of slack
	task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
		n_tests++;
		if ($isunknown(got) || got < lo || got > hi) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic axi_wr(input logic [4:0] a, input logic [31:0] w,
		output logic [1:0] r);
		bit aw_ok, w_ok;
		aw_ok = 0;
		w_ok = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= w;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		t_b = cyc;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [4:0] a, output logic [31:0] q,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		q = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] w);
		logic [1:0] r;
		axi_wr(a, w, r);
	endtask
	task automatic rd(input logic [4:0] a);
		axi_rd(a, d, resp);
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
		axi_rd(a, d, resp);
		chk(d, exp);
	endtask
	// run from zero for k cycles, then stop; e is the span in cycles
	task automatic run_span(input logic [31:0] c, input int k);
		int t0;
		wr(OFS_COUNT, 32'h0);
		wr(OFS_CONTROL, c);
		t0 = t_b;
		repeat (k) @(posedge aclk);
		wr(OFS_CONTROL, 32'h0);
		e = t_b - t0;
		rd(OFS_COUNT);
	endtask
	task automatic pulses(input int k);
		repeat (k) begin
			external_count_pin <= 1'b1;
			repeat (6) @(posedge aclk);
			external_count_pin <= 1'b0;
			repeat (6) @(posedge aclk);
		end
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		end_of_test();
	end

	initial begin
		{aresetn, external_count_pin, gate_pin} = 3'b000;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
		{s_axi_arvalid, s_axi_rready} = 2'b00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		ce = 1'b1;
		cyc = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(OFS_CONTROL, 32'h0);
		rd_chk(OFS_PERIOD, 32'hFFFF);
		rd_chk(OFS_COUNT, 32'h0);
		rd_chk(OFS_STATUS, 32'h0);
		rd_chk(OFS_MASK, 32'h0);
		rd_chk(OFS_POWER, 32'h0);
		axi_wr(5'h18, 32'hFFFF, resp);
		chk({30'h0, resp}, 32'h2);
		axi_rd(5'h1C, d, resp);
		chk({d[29:0], resp}, 32'h2);
		for (int i = 0; i < 8; i++) begin
			v = $random(seed);
			wr(OFS_PERIOD, v);
			rd_chk(OFS_PERIOD, {16'h0, v[15:0]});
			v = (i == 0) ? 32'hFFFF7FFF : $random(seed) & 32'hFFFF7FFF;
			wr(OFS_CONTROL, v);
			rd_chk(OFS_CONTROL, ctl_exp(v));
		end
		wr(OFS_CONTROL, 32'h0);
		wr(OFS_PERIOD, 32'hFFFF);
		// a stop that fails shows as extra counts during the read
		for (int p = 0; p < 4; p++) begin
			run_span(32'h8000 | (p << 4), 12 * div_of(p));
			chk_rng(d, e / div_of(p) - 1, e / div_of(p) + 1);
		end
		wr(OFS_PERIOD, 32'h9);
		wr(OFS_COUNT, 32'h0);
		wr(OFS_MASK, 32'h1);
		wr(OFS_CONTROL, 32'h8000);
		n = 0;
		while (irq !== 1'b1 && n < 40) begin
			@(posedge aclk);
			n++;
		end
		chk_rng(n, 8, 14);
		wr(OFS_CONTROL, 32'h0);
		rd_chk(OFS_STATUS, 32'h1);
		rd(OFS_COUNT);
		chk_rng(d, 0, 9);
		wr(OFS_STATUS, 32'h1);
		rd_chk(OFS_STATUS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_MASK, 32'h0);
		run_span(32'h8000, 30);
		rd_chk(OFS_STATUS, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_STATUS, 32'h3);
		wr(OFS_PERIOD, 32'hFFFF);
		wr(OFS_COUNT, 32'h0);
		wr(OFS_CONTROL, 32'h8040);
		repeat (10) @(posedge aclk);
		n = 20 + ($random(seed) & 31);
		gate_pin <= 1'b1;
		repeat (n) @(posedge aclk);
		gate_pin <= 1'b0;
		repeat (10) @(posedge aclk);
		wr(OFS_CONTROL, 32'h0);
		rd(OFS_COUNT);
		chk_rng(d, n - 2, n + 2);
		rd_chk(OFS_STATUS, 32'h2);
		wr(OFS_STATUS, 32'h3);
		// gate bit set with the pin source: gate low must not block counts
		for (int s = 0; s < 2; s++) begin
			n = 3 + ($random(seed) & 7);
			wr(OFS_COUNT, 32'h0);
			wr(OFS_CONTROL, 32'h8042 | (s << 2));
			pulses(n);
			// a last rise with no fall after it must still count
			external_count_pin <= 1'b1;
			gate_pin <= 1'b1;
			repeat (8) @(posedge aclk);
			gate_pin <= 1'b0;
			repeat (8) @(posedge aclk);
			wr(OFS_CONTROL, 32'h0);
			rd_chk(OFS_COUNT, n + 1);
			rd_chk(OFS_STATUS, 32'h0);
			external_count_pin <= 1'b0;
		end
		wr(OFS_POWER, 32'h1);
		run_span(32'hA000, 30);
		chk(d, 32'h0);
		run_span(32'h8000, 30);
		chk_rng(d, e - 1, e + 1);
		wr(OFS_POWER, 32'h2);
		run_span(32'hA000, 30);
		chk_rng(d, e - 1, e + 1);
		// ce low for 40 edges freezes the count with all other state
		wr(OFS_COUNT, 32'h0);
		wr(OFS_CONTROL, 32'h8000);
		n = t_b;
		repeat (5) @(posedge aclk);
		ce <= 1'b0;
		repeat (40) @(posedge aclk);
		ce <= 1'b1;
		wr(OFS_CONTROL, 32'h0);
		e = t_b - n - 40;
		rd(OFS_COUNT);
		chk_rng(d, e - 1, e + 1);
		// a second reset in mid-run restores the reset values
		wr(OFS_PERIOD, 32'h5);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(OFS_PERIOD, 32'hFFFF);
		rd_chk(OFS_POWER, 32'h0);
		end_of_test();
	end
endmodule // test_sbgt_timer
